/* File: hdl/didb_cfg.svh */
`ifndef DIDB_CFG_SVH
`define DIDB_CFG_SVH
// register word addresses
`define DIDB_ADDR_THRESH   4'h0
`define DIDB_ADDR_INCFG0   4'h1
`define DIDB_ADDR_OUTCFG0  4'h5
`define DIDB_ADDR_STATE    4'h9
// field positions
`define DIDB_THR_REF_BIT   5
`define DIDB_INCFG_MSB     14
`define DIDB_OUTCFG_MSB    1
// reset values
`define DIDB_THRESH_RST    6'h00
`define DIDB_INCFG_RST     15'h0000
`define DIDB_OUTCFG_RST    2'h0
// highest threshold code allowed with the supply reference
`define DIDB_THR_MAX_SUPPLY 5'h1D
// timing: clock period and comparator sample period in ns
`define DIDB_CLK_NS        100
`define DIDB_SAMPLE_NS     800
// debounce durations in units of 0.1 us, code 01 in the low entry
`define DIDB_DEB_TABLE { \
	20'hB71B0, 20'h88B83, 20'h668A4, 20'h4E205, 20'h3A986, 20'h2BF26, 20'h1FBD7, 20'h186A7, \
	20'h124FF, 20'h0DAC8, 20'h0A418, 20'h07D08, 20'h05DC8, 20'h04658, 20'h032D0, 20'h02718, \
	20'h01D50, 20'h015E2, 20'h0106B, 20'h00C83, 20'h00966, 20'h0070D, 20'h00515, 20'h003F0, \
	20'h002F4, 20'h00231, 20'h001A7, 20'h00145, 20'h000F4, 20'h000BB, 20'h00082 }
`define DIDB_DEB_UNIT_PER_US 10
// sample counts of the shortest and the longest debounce time
`define DIDB_DEB_SAMPLES_MIN 17
`define DIDB_DEB_SAMPLES_MAX 93750
`endif

/* File: hdl/didb_pkg.sv */
package didb_pkg;
	// channel function
	typedef enum logic [1:0] {FN_HIGHZ, FN_DIN_LOGIC, FN_LOOP_HART, FN_RTD} didb_func_t;
	// logic output pin source
	typedef enum logic [1:0] {OUT_LOW, OUT_HIGH, OUT_DEBOUNCED, OUT_SPARE} didb_out_src_t;
	typedef struct packed {
		didb_func_t func;
		logic [4:0] sink_code;
		logic       sink_range;
		logic       cmp_filtered;
		logic       deb_mode;
		logic [4:0] deb_time;
	} didb_chan_cfg_t;
	typedef struct packed {
		logic       ref_sel;
		logic [4:0] code;
	} didb_thr_t;
	typedef struct packed {
		logic       range;
		logic [4:0] code;
	} didb_sink_t;
endpackage

/* File: hdl/didb_top.sv */
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "didb_cfg.svh"
module didb_top
#(
	parameter int NCH     = 4,
	parameter int DEB_DIV = 1
)(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic [3:0]            addr,
	input  wire logic [15:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output logic [15:0]                rdata,
	input  wire logic [NCH-1:0]        cmp_unfiltered,
	input  wire logic [NCH-1:0]        cmp_filtered,
	output didb_pkg::didb_thr_t        threshold_out,
	output didb_pkg::didb_sink_t [NCH-1:0] sink_out,
	output logic [NCH-1:0]             hart_source_en,
	output logic [NCH-1:0]             adc_range_10v,
	output logic [NCH-1:0]             channel_logic_output_pin
);
	import didb_pkg::*;

	// ----------------------------------------
	// constants and helpers
	// ----------------------------------------
	localparam int TICK_CYC = `DIDB_SAMPLE_NS / `DIDB_CLK_NS;
	localparam int TW       = $clog2(TICK_CYC);
	localparam int CW       = 17;
	localparam logic [31*20-1:0] DEB_TABLE = `DIDB_DEB_TABLE;

	// duration over sample period, rounded up; DEB_DIV shortens it for simulation
	function automatic logic [CW-1:0] deb_target(input logic [4:0] code);
		int t;
		t = 0;
		if (code != 5'h00)
		begin
			t = int'(DEB_TABLE[(int'(code) - 1) * 20 +: 20]) * (1000 / `DIDB_DEB_UNIT_PER_US);
			t = (t + `DIDB_SAMPLE_NS - 1) / `DIDB_SAMPLE_NS / DEB_DIV;
			if (t < 1)
				t = 1;
		end
		return t[CW-1:0];
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	didb_thr_t                thr_reg;
	didb_chan_cfg_t [NCH-1:0] incfg_reg;
	didb_out_src_t  [NCH-1:0] outcfg_reg;
	logic [NCH-1:0]           state_reg;
	logic [TW-1:0]            tick_cnt_reg;
	logic                     tick_reg;
	logic [NCH-1:0]           sample;

	// software writes; unmapped addresses are ignored
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			thr_reg <= didb_thr_t'(`DIDB_THRESH_RST);
			for (int i = 0; i < NCH; i++)
			begin
				incfg_reg[i]  <= didb_chan_cfg_t'(`DIDB_INCFG_RST);
				outcfg_reg[i] <= didb_out_src_t'(`DIDB_OUTCFG_RST);
			end
		end
		else if (wr)
		begin
			if (addr == `DIDB_ADDR_THRESH)
				thr_reg <= didb_thr_t'(wdata[`DIDB_THR_REF_BIT:0]);
			for (int i = 0; i < NCH; i++)
			begin
				if (addr == `DIDB_ADDR_INCFG0 + 4'(i))
					incfg_reg[i] <= didb_chan_cfg_t'(wdata[`DIDB_INCFG_MSB:0]);
				if (addr == `DIDB_ADDR_OUTCFG0 + 4'(i))
					outcfg_reg[i] <= didb_out_src_t'(wdata[`DIDB_OUTCFG_MSB:0]);
			end
		end
	end

	// read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= 16'h0000;
		else if (!rd)
			rdata <= 16'h0000;
		else
		begin
			rdata <= 16'h0000;
			if (addr == `DIDB_ADDR_THRESH)
				rdata <= 16'(thr_reg);
			if (addr == `DIDB_ADDR_STATE)
				rdata <= 16'(state_reg);
			for (int i = 0; i < NCH; i++)
			begin
				if (addr == `DIDB_ADDR_INCFG0 + 4'(i))
					rdata <= 16'(incfg_reg[i]);
				if (addr == `DIDB_ADDR_OUTCFG0 + 4'(i))
					rdata <= 16'(outcfg_reg[i]);
			end
		end
	end

	// ----------------------------------------
	// analog control outputs
	// ----------------------------------------
	// out-of-range supply codes are clamped so the threshold never leaves the valid span
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			threshold_out <= didb_thr_t'(`DIDB_THRESH_RST);
		else
		begin
			threshold_out.ref_sel <= thr_reg.ref_sel;
			if (!thr_reg.ref_sel && thr_reg.code > `DIDB_THR_MAX_SUPPLY)
				threshold_out.code <= `DIDB_THR_MAX_SUPPLY;
			else
				threshold_out.code <= thr_reg.code;
		end
	end

	// sink settings and per-function controls
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sink_out       <= '0;
			hart_source_en <= '0;
			adc_range_10v  <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				sink_out[i].range <= incfg_reg[i].sink_range;
				sink_out[i].code  <= incfg_reg[i].sink_code;
				hart_source_en[i] <= incfg_reg[i].func == FN_LOOP_HART;
				adc_range_10v[i]  <= incfg_reg[i].func == FN_DIN_LOGIC;
			end
		end
	end

	// ----------------------------------------
	// comparator sampling
	// ----------------------------------------
	// free-running divider gives one tick per sample period
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end
		else
		begin
			tick_reg     <= tick_cnt_reg == TW'(TICK_CYC - 1);
			tick_cnt_reg <= (tick_cnt_reg == TW'(TICK_CYC - 1)) ? '0 : tick_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// debounce, one engine per channel
	// ----------------------------------------
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		logic [CW-1:0] cnt_reg;
		logic [CW-1:0] target;
		logic          differs;

		assign sample[g] = incfg_reg[g].cmp_filtered ? cmp_filtered[g] : cmp_unfiltered[g];
		assign target    = deb_target(incfg_reg[g].deb_time);
		assign differs   = sample[g] != state_reg[g];

		// state moves only on sample ticks; the converter plays no part here
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
			begin
				cnt_reg      <= '0;
				state_reg[g] <= 1'b0;
			end
			else if (tick_reg)
			begin
				if (incfg_reg[g].deb_time == 5'h00)
				begin
					state_reg[g] <= sample[g];
					cnt_reg      <= '0;
				end
				else if (differs && cnt_reg + 1'b1 >= target)
				begin
					state_reg[g] <= sample[g];
					cnt_reg      <= '0;
				end
				else if (differs)
					cnt_reg <= cnt_reg + 1'b1;
				else if (incfg_reg[g].deb_mode)
					cnt_reg <= '0;
				else if (cnt_reg != '0)
					cnt_reg <= cnt_reg - 1'b1;
			end
		end

		// pin drives a fixed level or the debounced result
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				channel_logic_output_pin[g] <= 1'b0;
			else
				channel_logic_output_pin[g] <= (outcfg_reg[g] == OUT_DEBOUNCED) ? state_reg[g] :
					(outcfg_reg[g] == OUT_HIGH);
		end

		// ----------------------------------------
		// checks
		// ----------------------------------------
		chk_hart_source: assert property (@(posedge clk) disable iff (!rstn)
			incfg_reg[g].func == FN_LOOP_HART |=> hart_source_en[g])
			else $error("hart source not enabled");
		chk_pin_follows: assert property (@(posedge clk) disable iff (!rstn)
			outcfg_reg[g] == OUT_DEBOUNCED |=> channel_logic_output_pin[g] == $past(state_reg[g]))
			else $error("pin does not follow debounced state");
		chk_bypass_pass: assert property (@(posedge clk) disable iff (!rstn)
			tick_reg && incfg_reg[g].deb_time == 5'h00 |=> state_reg[g] == $past(sample[g]))
			else $error("bypass did not pass sample");
		chk_state_on_tick: assert property (@(posedge clk) disable iff (!rstn)
			!tick_reg |=> $stable(state_reg[g]))
			else $error("state changed off tick");
		chk_mode1_reset: assert property (@(posedge clk) disable iff (!rstn)
			tick_reg && incfg_reg[g].deb_mode && !differs |=> cnt_reg == '0)
			else $error("mode 1 counter not reset");
		chk_target_reach: assert property (@(posedge clk) disable iff (!rstn)
			tick_reg && incfg_reg[g].deb_time != 5'h00 && $changed(incfg_reg[g]) == 1'b0 &&
			differs && cnt_reg + 1'b1 < target |=> state_reg[g] == $past(state_reg[g]))
			else $error("state changed before target");
		chk_mode0_down: assert property (@(posedge clk) disable iff (!rstn)
			tick_reg && !incfg_reg[g].deb_mode && incfg_reg[g].deb_time != 5'h00 &&
			!differs && cnt_reg != '0 |=> cnt_reg == $past(cnt_reg) - 1'b1)
			else $error("mode 0 did not count down");
		chk_hart_off: assert property (@(posedge clk) disable iff (!rstn)
			incfg_reg[g].func != FN_LOOP_HART |=> !hart_source_en[g])
			else $error("hart source on in another function");
		chk_range_default: assert property (@(posedge clk) disable iff (!rstn)
			incfg_reg[g].func == FN_DIN_LOGIC |=> adc_range_10v[g])
			else $error("converter range not defaulted");
		chk_sink_follow: assert property (@(posedge clk) disable iff (!rstn)
			1'b1 |=> sink_out[g].range == $past(incfg_reg[g].sink_range) &&
			sink_out[g].code == $past(incfg_reg[g].sink_code))
			else $error("sink setting not applied");
		chk_pin_fixed: assert property (@(posedge clk) disable iff (!rstn)
			outcfg_reg[g] != OUT_DEBOUNCED |=> channel_logic_output_pin[g] == ($past(outcfg_reg[g]) == OUT_HIGH))
			else $error("fixed pin level wrong");
		cov_mode0_change: cover property (@(posedge clk) disable iff (!rstn)
			tick_reg && !incfg_reg[g].deb_mode && incfg_reg[g].deb_time != 5'h00 ##1 $changed(state_reg[g]));
		cov_mode1_change: cover property (@(posedge clk) disable iff (!rstn)
			tick_reg && incfg_reg[g].deb_mode && incfg_reg[g].deb_time != 5'h00 ##1 $changed(state_reg[g]));
		cov_pin_rise: cover property (@(posedge clk) disable iff (!rstn)
			outcfg_reg[g] == OUT_DEBOUNCED ##1 $rose(channel_logic_output_pin[g]));
	end

	chk_tick_period: assert property (@(posedge clk) disable iff (!rstn)
		tick_reg |=> !tick_reg [*7] ##1 tick_reg)
		else $error("sample tick period wrong");
	chk_thr_clamp: assert property (@(posedge clk) disable iff (!rstn)
		!threshold_out.ref_sel |-> threshold_out.code <= `DIDB_THR_MAX_SUPPLY)
		else $error("supply threshold code above limit");
	chk_state_read: assert property (@(posedge clk) disable iff (!rstn)
		rd && addr == `DIDB_ADDR_STATE |=> rdata == 16'($past(state_reg)))
		else $error("state read wrong");
	chk_thr_follow: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> threshold_out.ref_sel == $past(thr_reg.ref_sel))
		else $error("threshold reference not applied");
	// the table ends as sample counts; long codes are far too slow to reach in a test run
	chk_table_ends: assert property (@(posedge clk) disable iff (!rstn)
		deb_target(5'h01) == CW'((`DIDB_DEB_SAMPLES_MIN >= DEB_DIV) ? `DIDB_DEB_SAMPLES_MIN / DEB_DIV : 1) &&
		deb_target(5'h1F) == CW'(`DIDB_DEB_SAMPLES_MAX / DEB_DIV))
		else $error("debounce table ends wrong");
	cov_bypass: cover property (@(posedge clk) disable iff (!rstn)
		tick_reg && incfg_reg[0].deb_time == 5'h00 ##1 $changed(state_reg[0]));
endmodule

/* File: dv/didb_sensor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// externally powered sensor on the terminals
// ----------------------------------------
module didb_sensor
#(
	parameter int FILT_DLY = 4
)(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] level,
	input  wire logic [3:0] spike,
	output logic      [3:0] cmp_unfiltered,
	output logic      [3:0] cmp_filtered
);
	logic [3:0] pipe [FILT_DLY];
	// spikes reach only the raw pin; the filter lags and swallows them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_unfiltered <= 4'h0;
			cmp_filtered <= 4'h0;
			for (int i = 0; i < FILT_DLY; i++)
				pipe[i] <= 4'h0;
		end
		else
		begin
			cmp_unfiltered <= level ^ spike;
			pipe[0] <= level;
			for (int i = 1; i < FILT_DLY; i++)
				pipe[i] <= pipe[i-1];
			cmp_filtered <= pipe[FILT_DLY-1];
		end
	end
endmodule

/* File: dv/digital_input_threshold_debounce_test.sv */
`timescale 1ns/1ps
module digital_input_threshold_debounce_test;
	import didb_pkg::*;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [3:0]        addr = 4'h0;
	logic [15:0]       wdata = 16'h0000;
	logic [15:0]       rdata;
	logic [3:0]        level = 4'h0;
	logic [3:0]        spike = 4'h0;
	logic [3:0]        cmp_u;
	logic [3:0]        cmp_f;
	logic [3:0]        hart;
	logic [3:0]        a10;
	logic [3:0]        pin;
	didb_thr_t         thr;
	didb_sink_t [3:0]  sink;
	int                errors = 0;
	int                tests_run = 0;

	// 10 MHz
	always #50 clk = ~clk;

	didb_sensor i_sensor (.clk(clk), .rstn(rstn), .level(level), .spike(spike),
		.cmp_unfiltered(cmp_u), .cmp_filtered(cmp_f));
	didb_top #(.NCH(4), .DEB_DIV(1)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cmp_unfiltered(cmp_u), .cmp_filtered(cmp_f),
		.threshold_out(thr), .sink_out(sink), .hart_source_en(hart), .adc_range_10v(a10),
		.channel_logic_output_pin(pin));

	// ----------------------------------------
	// bus and checking helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			errors++;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data are only valid in the cycle right after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd_reg(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	// config outputs trail the write by one more edge
	task automatic wrs(input logic [3:0] a, input logic [15:0] d);
		wr_reg(a, d);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic samples(input int n);
		repeat (8 * n) @(posedge clk);
	endtask
	// polls the state register; a state that never arrives ends the run
	task automatic wait_state(input logic [3:0] exp);
		logic [15:0] d;
		d = {12'h000, ~exp};
		for (int n = 0; n < 100 && d[3:0] !== exp; n++)
			rd_reg(4'h9, d);
		chk("state", d, {12'h000, exp});
		if (d[3:0] !== exp)
			end_of_test;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("thr_rst", {10'h000, thr}, 16'h0000);
		rchk(4'h1, 16'h0000);
		rchk(4'h5, 16'h0000);
		wr_reg(4'hA, 16'hFFFF);
		rchk(4'hA, 16'h0000);
		wr_reg(4'h9, 16'h000F);
		rchk(4'h9, 16'h0000);
	endtask
	task automatic t_thresh;
		wrs(4'h0, 16'h0030);
		chk("thr", {10'h000, thr}, 16'h0030);
		wrs(4'h0, 16'h001D);
		chk("thr", {10'h000, thr}, 16'h001D);
		rchk(4'h0, 16'h001D);
		wrs(4'h0, 16'hFFFF);
		chk("thr", {10'h000, thr}, 16'h003F);
		rchk(4'h0, 16'h003F);
	endtask
	task automatic t_sink;
		wrs(4'h1, 16'h5D80);
		chk("sink0", {10'h000, sink[0]}, 16'h003D);
		chk("hart", {12'h000, hart}, 16'h0001);
		chk("a10", {12'h000, a10}, 16'h0000);
		wrs(4'h1, 16'h3400);
		chk("sink0", {10'h000, sink[0]}, 16'h0014);
		chk("sink1", {10'h000, sink[1]}, 16'h0000);
		chk("a10", {12'h000, a10}, 16'h0001);
		chk("hart", {12'h000, hart}, 16'h0000);
		rchk(4'h1, 16'h3400);
		// resistance mode on channel 1; no converter setting is touched while it is in it
		wrs(4'h2, 16'h6000);
		chk("hart", {12'h000, hart}, 16'h0000);
		chk("a10", {12'h000, a10}, 16'h0001);
		wrs(4'h5, 16'h0001);
		chk("pin", {12'h000, pin}, 16'h0001);
		wrs(4'h5, 16'h0003);
		chk("pin", {12'h000, pin}, 16'h0000);
	endtask
	// two channels listen to the filtered pin, two to the raw one
	task automatic t_source;
		@(posedge clk);
		spike <= 4'hF;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(4'(1 + i), (i < 2) ? 16'h0040 : 16'h0000);
			wr_reg(4'(5 + i), 16'h0002);
		end
		wait_state(4'hC);
		chk("pin", {12'h000, pin}, 16'h000C);
		@(posedge clk);
		spike <= 4'h0;
		level <= 4'h5;
		wait_state(4'h5);
		@(posedge clk);
		level <= 4'h0;
		wait_state(4'h0);
	endtask
	// high for 10 samples, a 2 sample drop, then high again
	task automatic t_deb(input logic mode, input logic [15:0] exp_mid);
		wrs(4'h1, mode ? 16'h0021 : 16'h0001);
		samples(20);
		level <= 4'h1;
		samples(10);
		level <= 4'h0;
		samples(2);
		level <= 4'h1;
		samples(14);
		rchk(4'h9, exp_mid);
		wait_state(4'h1);
		@(posedge clk);
		level <= 4'h0;
		wait_state(4'h0);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_thresh;
		t_sink;
		t_source;
		t_deb(1'b0, 16'h0001);
		t_deb(1'b1, 16'h0000);
		end_of_test;
	end
endmodule
